// [hw/pfas_sequencer.sv]
// pump/fan motor sequencer with periodic autochange and interlocks, APB register slave
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`include "pfas_defs.svh"
module pfas_sequencer #(
  parameter int unsigned TICK_CYCLES = `PFAS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] digital_in,
  input wire logic [15:0] pump_fan_control,
  input wire logic aux_start_req,
  input wire logic aux_stop_req,
  output pfas_pkg::pfas_relays_t relays,
  output logic inverter_run,
  output logic inverter_coast,
  output logic [7:0] alarm_code
);
  import pfas_pkg::*;

  pfas_cfg_t cfg_r;
  logic [15:0] interval_r;
  logic [15:0] level_r;
  logic [15:0] wait_r;
  logic [15:0] icount_r;
  logic [1:0] order_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [4:0] din_meta_r;
  logic [4:0] din_sync_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [15:0] wait_cnt_r;
  pfas_state_t state_r;
  logic [1:0] reg_motor_r;
  logic reg_con_r;
  logic [3:0] dol_r;
  logic restore_r;
  logic inverter_run_r;
  logic inverter_coast_r;
  logic alarm_r;
  pfas_relays_t relays_r;
  logic [2:0] motor_n;
  logic auto_en;
  logic rotate_due;
  logic [3:0] ilk;
  logic [3:0] motor_on;
  logic reg_ok;
  logic [1:0] reg_pick;
  logic aux_ok;
  logic [1:0] aux_pick;
  logic stop_ok;
  logic [1:0] stop_pick;
  logic wr_en;
  logic rd_en;
  logic [1:0] order_nxt;

  assign motor_n = {1'b0, cfg_r.aux_motor_count} + 3'h1;
  assign auto_en = (interval_r != 16'h0000);

  function automatic logic [1:0] pos_motor(input logic [1:0] base, input logic [1:0] pos,
                                            input logic [2:0] n);
    logic [2:0] sum;
    sum = {1'b0, base} + {1'b0, pos};
    if (sum >= n) begin
      sum = sum - n;
    end
    return sum[1:0];
  endfunction : pos_motor

  // APB slave: zero wait states, read data captured in the setup cycle
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable;
  assign pready = psel && penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && psel && penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (rd_en) begin
      pslverr_r <= 1'b0;
      if (paddr == `PFAS_ADDR_CTRL) begin
        prdata_r <= {1'b0, cfg_r.ilk_sel, 2'h0, cfg_r.aux_motor_count, 3'h0,
                     cfg_r.relay_two_func, 3'h0, cfg_r.relay_one_func, 7'h00, cfg_r.run_cmd};
      end else if (paddr == `PFAS_ADDR_INTERVAL) begin
        prdata_r <= {16'h0000, interval_r};
      end else if (paddr == `PFAS_ADDR_LEVEL) begin
        prdata_r <= {16'h0000, level_r};
      end else if (paddr == `PFAS_ADDR_WAIT) begin
        prdata_r <= {16'h0000, wait_r};
      end else if (paddr == `PFAS_ADDR_STATUS) begin
        prdata_r <= {14'h0000, order_r, alarm_code, alarm_r, (state_r != ST_IDLE),
                     reg_motor_r, motor_on};
      end else if (paddr == `PFAS_ADDR_ICOUNT) begin
        prdata_r <= {16'h0000, icount_r};
      end else if (paddr == `PFAS_ADDR_ORDER) begin
        prdata_r <= {30'h0000_0000, order_r};
      end else begin
        prdata_r <= 32'h0000_0000;
        pslverr_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= pfas_cfg_t'(`PFAS_CTRL_RST);
      interval_r <= `PFAS_INTERVAL_RST;
      level_r <= `PFAS_LEVEL_RST;
      wait_r <= `PFAS_WAIT_RST;
    end else if (wr_en) begin
      if (paddr == `PFAS_ADDR_CTRL) begin
        cfg_r.run_cmd <= pwdata[`PFAS_CTRL_RUN];
        cfg_r.relay_one_func <= pwdata[`PFAS_CTRL_R1_LSB +: 5];
        cfg_r.relay_two_func <= pwdata[`PFAS_CTRL_R2_LSB +: 5];
        cfg_r.aux_motor_count <= pwdata[`PFAS_CTRL_AUX_LSB +: 2];
        cfg_r.ilk_sel <= pwdata[`PFAS_CTRL_ILK_LSB +: 3];
      end else if (paddr == `PFAS_ADDR_INTERVAL) begin
        interval_r <= pwdata[15:0];
      end else if (paddr == `PFAS_ADDR_LEVEL) begin
        level_r <= pwdata[15:0];
      end else if (paddr == `PFAS_ADDR_WAIT) begin
        wait_r <= pwdata[15:0];
      end
    end
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_r <= 5'h1F;
      din_sync_r <= 5'h1F;
    end else begin
      din_meta_r <= digital_in;
      din_sync_r <= din_meta_r;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_motor
      logic [2:0] idx;
      assign idx = cfg_r.ilk_sel - 3'h1 + 3'(k);
      assign ilk[k] = ((cfg_r.ilk_sel == 3'h1) || (cfg_r.ilk_sel == 3'h2)) &&
                      (3'(k) < motor_n) && !din_sync_r[idx];
      assign motor_on[k] = (reg_con_r && (reg_motor_r == 2'(k))) || dol_r[k];
    end
  endgenerate

  always_comb begin
    logic [1:0] m;
    m = 2'h0;
    reg_ok = 1'b0;
    reg_pick = 2'h0;
    aux_ok = 1'b0;
    aux_pick = 2'h0;
    stop_ok = 1'b0;
    stop_pick = 2'h0;
    for (int p = 3; p >= 0; p--) begin
      m = pos_motor(order_r, 2'(p), motor_n);
      if (3'(p) < motor_n) begin
        if (!ilk[m] && (auto_en || m == 2'h0)) begin
          reg_ok = 1'b1;
          reg_pick = m;
        end
        if (!ilk[m] && !motor_on[m]) begin
          aux_ok = 1'b1;
          aux_pick = m;
        end
      end
    end
    for (int p = 0; p < 4; p++) begin
      m = pos_motor(order_r, 2'(p), motor_n);
      if ((3'(p) < motor_n) && dol_r[m]) begin
        stop_ok = 1'b1;
        stop_pick = m;
      end
    end
  end

  // cyclic step of the starting order
  assign order_nxt = (3'({1'b0, order_r} + 3'h1) >= motor_n) ? 2'h0 : order_r + 2'h1;

  // tick prescaler; the time base only runs with the run command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (!cfg_r.run_cmd || tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = cfg_r.run_cmd && (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // interval counter, readable and restorable by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icount_r <= 16'h0000;
    end else if (state_r == ST_SWAP_ON) begin
      icount_r <= 16'h0000;
    end else if (wr_en && paddr == `PFAS_ADDR_ICOUNT) begin
      icount_r <= pwdata[15:0];
    end else if (tick && auto_en && icount_r < interval_r) begin
      icount_r <= icount_r + 16'h0001;
    end
  end

  // sleep does not gate the rotation
  assign rotate_due = auto_en && (icount_r >= interval_r) && (pump_fan_control < level_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_r <= 16'h0000;
    end else if (state_r != ST_WAIT) begin
      wait_cnt_r <= 16'h0000;
    end else if (tick) begin
      wait_cnt_r <= wait_cnt_r + 16'h0001;
    end
  end

  // sequencer; a dropped run command always wins and stops everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      reg_motor_r <= 2'h0;
      reg_con_r <= 1'b0;
      dol_r <= 4'h0;
      restore_r <= 1'b0;
      inverter_run_r <= 1'b0;
      inverter_coast_r <= 1'b0;
      alarm_r <= 1'b0;
      order_r <= 2'h0;
    end else if (!cfg_r.run_cmd) begin
      state_r <= ST_IDLE;
      reg_con_r <= 1'b0;
      dol_r <= 4'h0;
      restore_r <= 1'b0;
      inverter_run_r <= 1'b0;
      inverter_coast_r <= 1'b0;
      alarm_r <= 1'b0;
      if (wr_en && paddr == `PFAS_ADDR_ORDER) begin
        order_r <= pwdata[1:0];
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (reg_ok) begin
            alarm_r <= 1'b0;
            reg_motor_r <= reg_pick;
            reg_con_r <= 1'b1;
            state_r <= ST_WAIT;
          end else begin
            alarm_r <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (wait_cnt_r >= wait_r) begin
            inverter_run_r <= 1'b1;
            state_r <= restore_r ? ST_RESTART : ST_RUN;
          end
        end
        ST_RESTART: begin
          if (aux_ok) begin
            dol_r[aux_pick] <= 1'b1;
          end
          restore_r <= 1'b0;
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (rotate_due) begin
            inverter_run_r <= 1'b0;
            inverter_coast_r <= 1'b1;
            state_r <= ST_COAST;
          // aux requests are only honoured outside the swap sequence
          end else if (aux_start_req && aux_ok) begin
            dol_r[aux_pick] <= 1'b1;
          end else if (aux_stop_req && stop_ok) begin
            dol_r[stop_pick] <= 1'b0;
          end
        end
        ST_COAST: begin
          reg_con_r <= 1'b0;
          order_r <= order_nxt;
          state_r <= ST_SWAP_OFF;
        end
        ST_SWAP_OFF: begin
          // drop new motor if on line
          if (!reg_ok) begin
            alarm_r <= 1'b1;
          end else begin
            reg_motor_r <= reg_pick;
            if (dol_r[reg_pick]) begin
              dol_r[reg_pick] <= 1'b0;
              restore_r <= 1'b1;
            end
            state_r <= ST_SWAP_ON;
          end
        end
        ST_SWAP_ON: begin
          reg_con_r <= 1'b1;
          inverter_coast_r <= 1'b0;
          alarm_r <= 1'b0;
          state_r <= ST_WAIT;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    logic r1p;
    logic r2p;
    logic [2:0] base;
    if (!presetn) begin
      relays_r <= '0;
    end else begin
      r1p = (cfg_r.relay_one_func == `PFAS_PFC_FUNC);
      r2p = (cfg_r.relay_two_func == `PFAS_PFC_FUNC);
      base = 3'(r1p) + 3'(r2p);
      relays_r.relay_out_one <= r1p && motor_on[0];
      relays_r.relay_out_two <= r2p && motor_on[r1p ? 1 : 0];
      for (int j = 0; j < 4; j++) begin
        if ((base + 3'(j)) < motor_n) begin
          if (j < 2) begin
            relays_r.ext_one_out[j] <= motor_on[2'(base + 3'(j))];
          end else begin
            relays_r.ext_two_out[j - 2] <= motor_on[2'(base + 3'(j))];
          end
        end else if (j < 2) begin
          relays_r.ext_one_out[j] <= 1'b0;
        end else begin
          relays_r.ext_two_out[j - 2] <= 1'b0;
        end
      end
    end
  end

  assign relays = relays_r;
  assign inverter_run = inverter_run_r;
  assign inverter_coast = inverter_coast_r;
  assign alarm_code = alarm_r ? `PFAS_ALARM_ILK : 8'h00;

  chk_relay_func_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_r.relay_one_func != `PFAS_PFC_FUNC) |=> !relays.relay_out_one)
    else $error("relay one driven without pump/fan function");
  chk_fixed_regulated: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_en && reg_con_r && state_r == ST_RUN) |-> (reg_motor_r == 2'h0))
    else $error("regulated motor not motor one without autochange");
  chk_motor_count: assert property (@(posedge pclk) disable iff (!presetn)
    ($countones(motor_on) <= int'(motor_n)))
    else $error("more motors on than configured");
  chk_timer_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg_r.run_cmd && !(wr_en && paddr == `PFAS_ADDR_ICOUNT) && state_r != ST_SWAP_ON)
      |=> $stable(icount_r))
    else $error("interval counter moved without run command");
  chk_level_block: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_RUN && pump_fan_control > level_r) |=> (state_r != ST_COAST))
    else $error("autochange started above level limit");
  chk_coast_open: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_COAST && cfg_r.run_cmd) |=> (!inverter_run_r && !reg_con_r && inverter_coast_r))
    else $error("contactor opened while inverter switching");
  chk_order_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_COAST && cfg_r.run_cmd && motor_n > 3'h1) |=> (order_r != $past(order_r)))
    else $error("starting order did not step");
  chk_start_after_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(inverter_run_r) |-> $past(state_r == ST_WAIT && wait_cnt_r >= wait_r))
    else $error("motor started before start wait");
  chk_no_ilk_connect: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_SWAP_OFF && cfg_r.run_cmd && reg_ok) |=> ##1 (reg_con_r && !ilk[reg_motor_r]))
    else $error("interlocked motor connected");
  chk_alarm_code: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && cfg_r.run_cmd && !reg_ok) |=> (alarm_code == 8'h1E))
    else $error("interlock alarm missing");
  chk_aux_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_WAIT && cfg_r.run_cmd) |=> $stable(dol_r))
    else $error("aux motors changed during sequence");
  cov_autochange: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SWAP_ON ##1 state_r == ST_WAIT);
  cov_restore: cover property (@(posedge pclk) disable iff (!presetn) state_r == ST_RESTART);
  cov_alarm: cover property (@(posedge pclk) disable iff (!presetn) alarm_r);
  cov_aux_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(|dol_r));
endmodule : pfas_sequencer

// [hw/pfas_defs.svh]
// register map, field positions, reset values and timing counts of the pump/fan sequencer
`ifndef PFAS_DEFS_SVH
`define PFAS_DEFS_SVH
`define PFAS_ADDR_CTRL 12'h000
`define PFAS_ADDR_INTERVAL 12'h004
`define PFAS_ADDR_LEVEL 12'h008
`define PFAS_ADDR_WAIT 12'h00C
`define PFAS_ADDR_STATUS 12'h010
`define PFAS_ADDR_ICOUNT 12'h014
`define PFAS_ADDR_ORDER 12'h018
`define PFAS_CTRL_RUN 0
`define PFAS_CTRL_R1_LSB 8
`define PFAS_CTRL_R2_LSB 16
`define PFAS_CTRL_AUX_LSB 24
`define PFAS_CTRL_ILK_LSB 28
`define PFAS_STAT_MOTOR_LSB 0
`define PFAS_STAT_REG_LSB 4
`define PFAS_STAT_BUSY 6
`define PFAS_STAT_ALARM 7
`define PFAS_STAT_CODE_LSB 8
`define PFAS_STAT_ORDER_LSB 16
`define PFAS_CTRL_RST 32'h0000_0000
`define PFAS_INTERVAL_RST 16'h0000
`define PFAS_LEVEL_RST 16'hFFFF
`define PFAS_WAIT_RST 16'h0001
`define PFAS_PFC_FUNC 5'h1D
`define PFAS_ALARM_ILK 8'h1E
`define PFAS_CLK_PERIOD_NS 4
`define PFAS_TICK_NS 100000000
`define PFAS_TICK_CYCLES (`PFAS_TICK_NS / `PFAS_CLK_PERIOD_NS)
`endif

// [hw/pfas_pkg.sv]
// types shared by the pump/fan sequencer and its bench
package pfas_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_RESTART, ST_RUN, ST_COAST, ST_SWAP_OFF, ST_SWAP_ON
  } pfas_state_t;

  typedef struct packed {
    logic [2:0] ilk_sel;
    logic [1:0] aux_motor_count;
    logic [4:0] relay_two_func;
    logic [4:0] relay_one_func;
    logic run_cmd;
  } pfas_cfg_t;

  typedef struct packed {
    logic relay_out_one;
    logic relay_out_two;
    logic [1:0] ext_one_out;
    logic [1:0] ext_two_out;
  } pfas_relays_t;
endpackage : pfas_pkg

// [tb/pfas_motor_model.sv]
// far side model: interlock contacts driven from ilk_mask, registered once; the relays are not used
`timescale 1ns/100ps
module pfas_motor_model (
  input wire logic pclk,
  input wire pfas_pkg::pfas_relays_t relays,
  input wire logic [4:0] ilk_mask,
  output logic [4:0] digital_in
);
  import pfas_pkg::*;
  always_ff @(posedge pclk) begin
    digital_in <= ~ilk_mask;
  end
endmodule : pfas_motor_model

// [tb/pfas_sequencer_tb.sv]
// self-checking bench of the pump/fan sequencer
`timescale 1ns/100ps
`include "pfas_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
`define WAIT1(s, n) for (int k = 0; k < n && (s) !== 1'b1; k++) @(posedge pclk);
module pfas_sequencer_tb;
  import pfas_pkg::*;
  // short tick keeps interval and start wait counts small
  localparam int unsigned TICKS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] digital_in;
  logic [4:0] ilk_mask = 5'h00;
  logic [15:0] pump_fan_control = 16'h1000;
  logic aux_start_req = 1'b0;
  logic aux_stop_req = 1'b0;
  pfas_relays_t relays;
  logic inverter_run;
  logic inverter_coast;
  logic [7:0] alarm_code;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int cmp_count = 0;

  always #2 pclk = ~pclk;

  pfas_sequencer #(.TICK_CYCLES(TICKS)) i_pfas_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_in(digital_in), .pump_fan_control(pump_fan_control),
    .aux_start_req(aux_start_req), .aux_stop_req(aux_stop_req), .relays(relays),
    .inverter_run(inverter_run), .inverter_coast(inverter_coast),
    .alarm_code(alarm_code)
  );

  pfas_motor_model i_pfas_motor_model (
    .pclk(pclk), .relays(relays), .ilk_mask(ilk_mask), .digital_in(digital_in)
  );

  function automatic logic [31:0] ctrl(input logic run, input logic [4:0] f1,
    input logic [4:0] f2, input logic [1:0] aux, input logic [2:0] sel);
    ctrl = 32'h0;
    ctrl[`PFAS_CTRL_RUN] = run;
    ctrl[`PFAS_CTRL_R1_LSB +: 5] = f1;
    ctrl[`PFAS_CTRL_R2_LSB +: 5] = f2;
    ctrl[`PFAS_CTRL_AUX_LSB +: 2] = aux;
    ctrl[`PFAS_CTRL_ILK_LSB +: 3] = sel;
  endfunction : ctrl

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("MISMATCH apb pready exp 1 got %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic stop);
    if (stop) aux_stop_req <= 1'b1;
    else aux_start_req <= 1'b1;
    @(posedge pclk);
    aux_stop_req <= 1'b0;
    aux_start_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task automatic t_regs;
    apb(1'b0, `PFAS_ADDR_CTRL, 32'h0);
    `CHK("ctrl rst", `PFAS_CTRL_RST, rd)
    apb(1'b0, `PFAS_ADDR_INTERVAL, 32'h0);
    `CHK("interval rst", {16'h0, `PFAS_INTERVAL_RST}, rd)
    apb(1'b0, `PFAS_ADDR_LEVEL, 32'h0);
    `CHK("level rst", {16'h0, `PFAS_LEVEL_RST}, rd)
    apb(1'b0, `PFAS_ADDR_WAIT, 32'h0);
    `CHK("wait rst", {16'h0, `PFAS_WAIT_RST}, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, er)
  endtask : t_regs

  // relay allocation for every relay setting, autochange off
  task automatic t_alloc;
    logic [4:0] f1[4] = '{`PFAS_PFC_FUNC, `PFAS_PFC_FUNC, 5'h00, 5'h00};
    logic [4:0] f2[4] = '{`PFAS_PFC_FUNC, 5'h00, `PFAS_PFC_FUNC, 5'h00};
    logic [5:0] e_reg[4] = '{6'b100000, 6'b100000, 6'b010000, 6'b000100};
    logic [5:0] e_aux[4] = '{6'b110000, 6'b100100, 6'b010100, 6'b001100};
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `PFAS_ADDR_CTRL, ctrl(1'b1, f1[c], f2[c], 2'd1, 3'd1));
      `WAIT1(inverter_run, 200)
      `CHK("regulated relay", e_reg[c], relays)
      pulse(1'b0);
      `CHK("aux relay", e_aux[c], relays)
      pulse(1'b1);
      `CHK("aux stopped", e_reg[c], relays)
      apb(1'b1, `PFAS_ADDR_CTRL, ctrl(1'b0, f1[c], f2[c], 2'd1, 3'd1));
      repeat (3) @(posedge pclk);
      `CHK("all open", 6'b000000, relays)
    end
  endtask : t_alloc

  // interlock input mapping and start refusal
  task automatic t_ilk;
    logic [2:0] sel[4] = '{3'd1, 3'd2, 3'd2, 3'd0};
    logic [4:0] msk[4] = '{5'b00001, 5'b00001, 5'b00010, 5'b11111};
    logic alm[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int c = 0; c < 4; c++) begin
      ilk_mask <= msk[c];
      apb(1'b1, `PFAS_ADDR_CTRL, ctrl(1'b1, `PFAS_PFC_FUNC, 5'h00, 2'd1, sel[c]));
      repeat (6) @(posedge pclk);
      `CHK("alarm", alm[c] ? `PFAS_ALARM_ILK : 8'h00, alarm_code)
      `CHK("start refused", ~alm[c], relays.relay_out_one)
      apb(1'b1, `PFAS_ADDR_CTRL, 32'h0);
      ilk_mask <= 5'h00;
      repeat (4) @(posedge pclk);
    end
  endtask : t_ilk

  task automatic t_rot;
    int cnt;
    apb(1'b1, `PFAS_ADDR_LEVEL, 32'h8000);
    apb(1'b1, `PFAS_ADDR_INTERVAL, 32'h3);
    apb(1'b1, `PFAS_ADDR_CTRL, ctrl(1'b1, `PFAS_PFC_FUNC, `PFAS_PFC_FUNC, 2'd1, 3'd1));
    `WAIT1(inverter_run, 200)
    `CHK("first motor", 6'b100000, relays)
    `WAIT1(inverter_coast, 300)
    `CHK("coast stops drive", 1'b0, inverter_run)
    `WAIT1(inverter_run, 300)
    pump_fan_control <= 16'h9000;
    `CHK("swapped", 6'b010000, relays)
    apb(1'b0, `PFAS_ADDR_STATUS, 32'h0);
    `CHK("order", 2'd1, rd[`PFAS_STAT_ORDER_LSB +: 2])
    cnt = 0;
    repeat (200) begin
      @(posedge pclk);
      if (inverter_coast === 1'b1) cnt++;
    end
    `CHK("blocked", 0, cnt)
    pump_fan_control <= 16'h1000;
    `WAIT1(inverter_coast, 300)
    `CHK("rotates again", 1'b1, inverter_coast)
    apb(1'b1, `PFAS_ADDR_CTRL, 32'h0);
    apb(1'b0, `PFAS_ADDR_ICOUNT, 32'h0);
    cnt = int'(rd);
    repeat (100) @(posedge pclk);
    apb(1'b0, `PFAS_ADDR_ICOUNT, 32'h0);
    `CHK("interval held", cnt, int'(rd))
  endtask : t_rot

  // counters restored by software; the start skips an interlocked motor
  task automatic t_save;
    ilk_mask <= 5'b00010;
    pump_fan_control <= 16'h9000;
    apb(1'b1, `PFAS_ADDR_ORDER, 32'h1);
    apb(1'b0, `PFAS_ADDR_ORDER, 32'h0);
    `CHK("order restore", 32'h1, rd)
    apb(1'b1, `PFAS_ADDR_ICOUNT, 32'h2);
    apb(1'b0, `PFAS_ADDR_ICOUNT, 32'h0);
    `CHK("interval restore", 32'h2, rd)
    apb(1'b1, `PFAS_ADDR_CTRL, ctrl(1'b1, `PFAS_PFC_FUNC, `PFAS_PFC_FUNC, 2'd1, 3'd1));
    `WAIT1(inverter_run, 200)
    `CHK("skip interlocked", 6'b100000, relays)
    apb(1'b1, `PFAS_ADDR_CTRL, 32'h0);
    ilk_mask <= 5'h00;
    pump_fan_control <= 16'h1000;
    repeat (4) @(posedge pclk);
  endtask : t_save

  task automatic finish_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_alloc();
    t_ilk();
    t_rot();
    t_save();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
endmodule : pfas_sequencer_tb
